//--- shared/pib_pkg.sv
package pib_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the plain register port)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_ENABLE_A = 4'h0;
	localparam logic [3:0] ADDR_ENABLE_B = 4'h1;
	localparam logic [3:0] ADDR_ENABLE_C = 4'h2;
	localparam logic [3:0] ADDR_CC_FLAGS = 4'h3;
	localparam logic [3:0] ADDR_CONTROL = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
	localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h6;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h7;

	// ----------------------------------------------------------------
	// Reset values and field layouts
	// ----------------------------------------------------------------
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] ENABLE_B_MASK = 8'hCB;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam int EN_A_PARALLEL = 7;
	localparam int EN_A_CONVERTER = 6;
	localparam int EN_A_SER1_RX = 5;
	localparam int EN_A_SER1_TX = 4;
	localparam int EN_A_SYNC1 = 3;
	localparam int EN_A_CAPCOMP1 = 2;
	localparam int EN_A_TMR2_MATCH = 1;
	localparam int EN_A_TMR1_OVF = 0;
	localparam int EN_B_OSC_FAIL = 7;
	localparam int EN_B_COMPARATOR = 6;
	localparam int EN_B_COLLISION = 3;
	localparam int EN_B_TMR3_OVF = 1;
	localparam int EN_B_CAPCOMP2 = 0;
	localparam int CTRL_PRIO_EN = 0;
	localparam int CTRL_GLOBAL_EN = 1;
	localparam int NUM_CC = 2;
	localparam int NUM_EVT = 3;
	localparam int EVT_REQ_RISE = 2;

	// Capture/compare unit operating modes
	typedef enum logic [1:0] {
		CC_CAPTURE = 2'b00,
		CC_COMPARE = 2'b01,
		CC_PWM = 2'b10
	} pib_ccmode_e;

endpackage

//--- hdl/pib_enable_bank.sv
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module pib_enable_bank #(
	parameter int ADDR_W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Peripheral request flags
	input wire logic [7:0] periph_flags_a,
	input wire logic [7:0] periph_flags_b,
	input wire logic [7:0] periph_flags_c,
	// Capture/compare units three and four
	input wire logic [1:0] capcomp_mode [pib_pkg::NUM_CC],
	input wire logic [pib_pkg::NUM_CC-1:0] capcomp_event,
	// Towards the core
	output logic periph_irq,
	output logic priority_levels_enable,
	output logic peripheral_global_enable,
	output logic [pib_pkg::NUM_CC-1:0] capcomp_irq_flag,
	// Block interrupt
	output logic irq
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	// Wider addresses would alias onto the map through the cast below
	if (ADDR_W < 3 || ADDR_W > 4) begin : g_bad_addr
		$error("ADDR_W must be 3 or 4 to decode without aliasing");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] en_a;
		logic [7:0] en_b;
		logic [7:0] en_c;
		logic [pib_pkg::NUM_CC-1:0] cc_flag;
		logic prio_en;
		logic global_en;
		logic [pib_pkg::NUM_EVT-1:0] stat;
		logic [pib_pkg::NUM_EVT-1:0] stat_en;
		logic req;
		logic [7:0] rdata;
	} pib_state_s;

	pib_state_s st_reg;
	pib_state_s st_next;

	logic [7:0] pend_a;
	logic [7:0] pend_b;
	logic [7:0] pend_c;
	logic [7:0] flags_c_eff;
	logic any_pend;
	logic req_next;
	logic [pib_pkg::NUM_CC-1:0] cc_set;
	logic [pib_pkg::NUM_EVT-1:0] evt;
	logic [3:0] addr;

	assign addr = 4'(reg_addr);

	// ----------------------------------------------------------------
	// Source gating
	// ----------------------------------------------------------------
	// Flags of units three and four stand in group c bits 0 and 1
	assign flags_c_eff = {periph_flags_c[7:2], st_reg.cc_flag};
	assign pend_a = periph_flags_a & st_reg.en_a;
	assign pend_b = periph_flags_b & st_reg.en_b;
	assign pend_c = flags_c_eff & st_reg.en_c;
	assign any_pend = |{pend_a, pend_b, pend_c};

	// Capture or compare event per unit; PWM mode raises nothing
	genvar gi;
	for (gi = 0; gi < pib_pkg::NUM_CC; gi++) begin : g_cc
		assign cc_set[gi] = capcomp_event[gi] &&
			(capcomp_mode[gi] != pib_pkg::CC_PWM);
	end

	// Global gating of the request towards the core
	assign req_next = any_pend &&
		(st_reg.prio_en || st_reg.global_en);

	// Block interrupt events; bit 2 marks a rising request
	assign evt = {req_next && !st_reg.req, cc_set};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.rdata = pib_pkg::READ_ZERO;
		// Register writes
		if (reg_wr) begin
			unique case (addr)
				pib_pkg::ADDR_ENABLE_A: st_next.en_a = reg_wdata;
				pib_pkg::ADDR_ENABLE_B:
					st_next.en_b = reg_wdata & pib_pkg::ENABLE_B_MASK;
				pib_pkg::ADDR_ENABLE_C: st_next.en_c = reg_wdata;
				pib_pkg::ADDR_CC_FLAGS:
					st_next.cc_flag = st_reg.cc_flag &
						reg_wdata[pib_pkg::NUM_CC-1:0];
				pib_pkg::ADDR_CONTROL: begin
					st_next.prio_en = reg_wdata[pib_pkg::CTRL_PRIO_EN];
					st_next.global_en = reg_wdata[pib_pkg::CTRL_GLOBAL_EN];
				end
				pib_pkg::ADDR_IRQ_CLEAR:
					st_next.stat = st_reg.stat &
						~reg_wdata[pib_pkg::NUM_EVT-1:0];
				pib_pkg::ADDR_IRQ_ENABLE:
					st_next.stat_en = reg_wdata[pib_pkg::NUM_EVT-1:0];
				default: ;
			endcase
		end
		// Hardware set wins over a software clear
		st_next.cc_flag = st_next.cc_flag | cc_set;
		// Request towards the core, gated above
		st_next.req = req_next;
		st_next.stat = st_next.stat | evt;
		// Register reads, data valid the following cycle
		if (reg_rd) begin
			unique case (addr)
				pib_pkg::ADDR_ENABLE_A: st_next.rdata = st_reg.en_a;
				pib_pkg::ADDR_ENABLE_B:
					st_next.rdata = st_reg.en_b & pib_pkg::ENABLE_B_MASK;
				pib_pkg::ADDR_ENABLE_C: st_next.rdata = st_reg.en_c;
				pib_pkg::ADDR_CC_FLAGS:
					st_next.rdata = 8'(st_reg.cc_flag);
				pib_pkg::ADDR_CONTROL: begin
					st_next.rdata[pib_pkg::CTRL_PRIO_EN] = st_reg.prio_en;
					st_next.rdata[pib_pkg::CTRL_GLOBAL_EN] = st_reg.global_en;
				end
				pib_pkg::ADDR_IRQ_STATUS: st_next.rdata = 8'(st_reg.stat);
				pib_pkg::ADDR_IRQ_ENABLE:
					st_next.rdata = 8'(st_reg.stat_en);
				default: st_next.rdata = pib_pkg::READ_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs
	assign reg_rdata = st_reg.rdata;
	assign periph_irq = st_reg.req;
	assign priority_levels_enable = st_reg.prio_en;
	assign peripheral_global_enable = st_reg.global_en;
	assign capcomp_irq_flag = st_reg.cc_flag;
	assign irq = |(st_reg.stat & st_reg.stat_en);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	logic gate_open;
	logic other_pend_a;
	assign gate_open = st_reg.prio_en || st_reg.global_en;
	assign other_pend_a = |{pend_b, pend_c};

	AST_CC_SET: assert property (
		capcomp_event[0] && capcomp_mode[0] == pib_pkg::CC_CAPTURE
		|=> capcomp_irq_flag[0])
		else $error("capture did not set unit flag");

	AST_CC_HOLD: assert property (
		capcomp_irq_flag[1] && !(reg_wr && addr == pib_pkg::ADDR_CC_FLAGS)
		|=> capcomp_irq_flag[1])
		else $error("unit flag dropped without a clear");

	AST_EN_C_WRITE: assert property (
		reg_wr && addr == pib_pkg::ADDR_ENABLE_C ##1 !reg_wr
		##1 reg_rd && addr == pib_pkg::ADDR_ENABLE_C && !reg_wr
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("third enable register lost its value");

	AST_GLOBAL_GATE: assert property (
		!priority_levels_enable && !peripheral_global_enable
		|=> !periph_irq)
		else $error("request passed with global enable clear");

	AST_PARALLEL_PASS: assert property (
		gate_open && periph_flags_a[pib_pkg::EN_A_PARALLEL]
		&& st_reg.en_a[pib_pkg::EN_A_PARALLEL] |=> periph_irq)
		else $error("parallel port request not passed");

	AST_CONVERTER_BLOCK: assert property (
		periph_flags_a == 8'h40 && !st_reg.en_a[pib_pkg::EN_A_CONVERTER]
		&& !other_pend_a |=> !periph_irq)
		else $error("converter request passed while disabled");

	AST_SER1_PASS: assert property (
		gate_open && periph_flags_a[pib_pkg::EN_A_SER1_TX]
		&& st_reg.en_a[pib_pkg::EN_A_SER1_TX] |=> periph_irq)
		else $error("serial transmit request not passed");

	AST_SYNC1_PASS: assert property (
		gate_open && periph_flags_a[pib_pkg::EN_A_SYNC1]
		&& st_reg.en_a[pib_pkg::EN_A_SYNC1] |=> periph_irq)
		else $error("sync port request not passed");

	AST_TMR1_PASS: assert property (
		gate_open && periph_flags_a[pib_pkg::EN_A_TMR1_OVF]
		&& st_reg.en_a[pib_pkg::EN_A_TMR1_OVF] |=> periph_irq)
		else $error("timer1 overflow request not passed");

	AST_B_RESERVED: assert property (
		reg_rd && addr == pib_pkg::ADDR_ENABLE_B
		|=> (reg_rdata & ~pib_pkg::ENABLE_B_MASK) == 8'h00)
		else $error("unimplemented enable bits read nonzero");

	AST_CONVERTER_PASS: assert property (
		gate_open && periph_flags_a[pib_pkg::EN_A_CONVERTER]
		&& st_reg.en_a[pib_pkg::EN_A_CONVERTER] |=> periph_irq)
		else $error("converter request not passed");

	AST_SER1_RX_PASS: assert property (
		gate_open && periph_flags_a[pib_pkg::EN_A_SER1_RX]
		&& st_reg.en_a[pib_pkg::EN_A_SER1_RX] |=> periph_irq)
		else $error("serial receive request not passed");

	AST_CAPCOMP1_PASS: assert property (
		gate_open && periph_flags_a[pib_pkg::EN_A_CAPCOMP1]
		&& st_reg.en_a[pib_pkg::EN_A_CAPCOMP1] |=> periph_irq)
		else $error("capcomp1 request not passed");

	AST_TMR2_PASS: assert property (
		gate_open && periph_flags_a[pib_pkg::EN_A_TMR2_MATCH]
		&& st_reg.en_a[pib_pkg::EN_A_TMR2_MATCH] |=> periph_irq)
		else $error("timer2 match request not passed");

	AST_B_PASS: assert property (
		gate_open && periph_flags_b[pib_pkg::EN_B_CAPCOMP2]
		&& st_reg.en_b[pib_pkg::EN_B_CAPCOMP2] |=> periph_irq)
		else $error("second enable register source not passed");

	AST_C_PASS: assert property (
		gate_open && capcomp_irq_flag[0] && st_reg.en_c[0]
		|=> periph_irq)
		else $error("third enable register source not passed");

	AST_PRIO_PASS: assert property (
		priority_levels_enable && |(periph_flags_a & st_reg.en_a)
		|=> periph_irq)
		else $error("request blocked with priority levels on");

	AST_CC1_SET: assert property (
		capcomp_event[1] && capcomp_mode[1] != pib_pkg::CC_PWM
		|=> capcomp_irq_flag[1])
		else $error("event did not set second unit flag");

	AST_PWM_IGNORED: assert property (
		capcomp_event[1] && capcomp_mode[1] == pib_pkg::CC_PWM
		&& !capcomp_irq_flag[1] |=> !capcomp_irq_flag[1])
		else $error("pwm event set a unit flag");

	AST_CC_CLEAR: assert property (
		reg_wr && addr == pib_pkg::ADDR_CC_FLAGS && !reg_wdata[0]
		&& !capcomp_event[0] |=> !capcomp_irq_flag[0])
		else $error("software clear did not drop unit flag");

	AST_STATUS_SET: assert property (
		capcomp_event[0] && capcomp_mode[0] != pib_pkg::CC_PWM
		|=> st_reg.stat[0])
		else $error("capture event missing from status");

	AST_RDATA_IDLE: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside its read cycle");

	// Main scenarios
	COV_CAPTURE_IRQ: cover property (
		capcomp_event[0] ##1 capcomp_irq_flag[0] ##[1:4] irq);
	COV_PRIO_PATH: cover property (
		priority_levels_enable && !peripheral_global_enable && periph_irq);
	COV_FLAG_CLEAR: cover property (
		capcomp_irq_flag[1] ##1 !capcomp_irq_flag[1]);
	COV_PWM_EVENT: cover property (
		capcomp_event[1] && capcomp_mode[1] == pib_pkg::CC_PWM);
	COV_C_GATE: cover property (
		capcomp_irq_flag[0] && st_reg.en_c[0] ##1 periph_irq);

endmodule

//--- tb/pib_periph_model.sv
`timescale 1ns/1ps
// Peripheral side: flag levels and capture/compare pulses
module pib_periph_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Bench commands
	input wire logic [23:0] want,
	input wire logic [1:0] fire,
	input wire logic [1:0] fire_mode,
	// Towards the block
	output logic [7:0] flags_a,
	output logic [7:0] flags_b,
	output logic [7:0] flags_c,
	output logic [1:0] mode [pib_pkg::NUM_CC],
	output logic [1:0] event_q
);
	// Levels follow the command a cycle late, pulses last one cycle
	always_ff @(posedge clk) begin
		{flags_c, flags_b, flags_a} <= reset ? 24'h00_0000 : want;
		event_q <= reset ? 2'b00 : fire;
		mode[0] <= fire_mode;
		mode[1] <= fire_mode;
	end
endmodule

//--- tb/tb_pib_enable_bank.sv
`timescale 1ns/1ps
module tb_pib_enable_bank;
	// ----
	// Signals
	// ----
	logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
	logic [3:0] reg_addr = 4'h0, ra;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, fa, fb, fc, v;
	logic [23:0] want = 24'h00_0000;
	logic [1:0] fire = 2'b00, fmode = 2'b00, cc_ev, cc_flag;
	logic [1:0] cc_mode [pib_pkg::NUM_CC];
	logic periph_irq, prio_en, glob_en, irq;
	logic [7:0] exp_q [$];
	logic [31:0] seed = 32'h0000_0040;
	int err_total = 0, checks_done = 0, cycles = 0;

	// Clock
	initial begin
		forever #5 clk = ~clk;
	end

	pib_periph_model pib_periph_model_i (.clk(clk), .reset(reset),
		.want(want), .fire(fire), .fire_mode(fmode), .flags_a(fa),
		.flags_b(fb), .flags_c(fc), .mode(cc_mode), .event_q(cc_ev));
	pib_enable_bank pib_enable_bank_i (.clk(clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_flags_a(fa),
		.periph_flags_b(fb), .periph_flags_c(fc), .capcomp_mode(cc_mode),
		.capcomp_event(cc_ev), .periph_irq(periph_irq),
		.priority_levels_enable(prio_en), .peripheral_global_enable(glob_en),
		.capcomp_irq_flag(cc_flag), .irq(irq));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic give_verdict();
		if (err_total == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	// Output settles within two cycles of a write or a flag change; the wait is three
	// The output is sampled after the wait, not at the call
	task automatic pchk(string n, logic e);
		repeat (3) @(posedge clk);
		if (n == "irq") begin
			chk(n, {7'h00, e}, {7'h00, irq});
		end else begin
			chk(n, {7'h00, e}, {7'h00, periph_irq});
		end
	endtask
	task automatic fire_evt(logic [1:0] u, logic [1:0] m);
		@(posedge clk);
		fire <= u;
		fmode <= m;
		@(posedge clk);
		fire <= 2'b00;
	endtask

	// Read data taken off the queue the cycle after the strobe; timeout
	always @(posedge clk) begin
		if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
		rd_d <= reg_rd;
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			give_verdict();
		end
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(pib_pkg::ADDR_ENABLE_A, 8'h00);
		rd(pib_pkg::ADDR_ENABLE_B, 8'h00);
		for (int k = 0; k < 4; k++) begin
			v = 8'(xs());
			wr(pib_pkg::ADDR_ENABLE_A, v);
			wr(pib_pkg::ADDR_ENABLE_B, v);
			wr(pib_pkg::ADDR_ENABLE_C, ~v);
			rd(pib_pkg::ADDR_ENABLE_C, ~v);
			rd(pib_pkg::ADDR_ENABLE_A, v);
			rd(pib_pkg::ADDR_ENABLE_B, v & pib_pkg::ENABLE_B_MASK);
		end
		rd(4'h8, 8'h00);
		rd(pib_pkg::ADDR_IRQ_CLEAR, 8'h00);
		// Each implemented enable bit of the first two registers passes its own source and nothing else
		wr(pib_pkg::ADDR_CONTROL, 8'h02);
		for (int i = 0; i < 16; i++) begin
			v = 8'h01 << (i % 8);
			ra = i < 8 ? pib_pkg::ADDR_ENABLE_A : pib_pkg::ADDR_ENABLE_B;
			want <= i < 8 ? {16'h0000, v} : {8'h00, v, 8'h00};
			wr(ra, v);
			pchk("periph_irq",
				i < 8 || |(v & pib_pkg::ENABLE_B_MASK));
			wr(ra, ~v);
			pchk("periph_irq", 1'b0);
		end
		// Priority levels gate without the global enable
		want <= 24'h00_00FF;
		wr(pib_pkg::ADDR_ENABLE_A, 8'hFF);
		wr(pib_pkg::ADDR_CONTROL, 8'h00);
		pchk("periph_irq", 1'b0);
		wr(pib_pkg::ADDR_CONTROL, 8'h01);
		pchk("periph_irq", 1'b1);
		chk("control", 8'h01, {6'h00, glob_en, prio_en});
		wr(pib_pkg::ADDR_CONTROL, 8'h00);
		want <= 24'h00_0000;
		// Capture flags: sticky, pwm ignored, raise and clear irq
		wr(pib_pkg::ADDR_IRQ_CLEAR, 8'hFF);
		wr(pib_pkg::ADDR_IRQ_ENABLE, 8'h01);
		fire_evt(2'b01, pib_pkg::CC_CAPTURE);
		pchk("irq", 1'b1);
		chk("capcomp_irq_flag", 8'h01, {6'h00, cc_flag});
		fire_evt(2'b10, pib_pkg::CC_PWM);
		rd(pib_pkg::ADDR_CC_FLAGS, 8'h01);
		rd(pib_pkg::ADDR_IRQ_STATUS, 8'h01);
		// Third enable register gates the held unit flag
		wr(pib_pkg::ADDR_CONTROL, 8'h02);
		wr(pib_pkg::ADDR_ENABLE_C, 8'h01);
		pchk("periph_irq", 1'b1);
		wr(pib_pkg::ADDR_CONTROL, 8'h00);
		wr(pib_pkg::ADDR_CC_FLAGS, 8'h00);
		rd(pib_pkg::ADDR_CC_FLAGS, 8'h00);
		wr(pib_pkg::ADDR_IRQ_CLEAR, 8'h05);
		pchk("irq", 1'b0);
		wr(pib_pkg::ADDR_IRQ_ENABLE, 8'h00);
		fire_evt(2'b10, pib_pkg::CC_COMPARE);
		pchk("irq", 1'b0);
		chk("capcomp_irq_flag", 8'h02, {6'h00, cc_flag});
		rd(pib_pkg::ADDR_IRQ_STATUS, 8'h02);
		rd(pib_pkg::ADDR_CC_FLAGS, 8'h02);
		repeat (2) @(posedge clk);
		give_verdict();
	end
endmodule
